/* hdl/gcp_pkg.sv */
/*
 global clock and pll control package: register map, field positions, reset values, pll timing
 and the bus carrier structs.
 assumes a 32-bit apb master and a 50 MHz pclk.
*/
// Operation
// [R1] eight global buffers reach every tile clock
// [R2] any four buffers selectable as tile lut inputs
// [R3] even buffers set/reset, odd buffers clock enable
// [R4] buffers 7,6,3..0 pins; 4 low-power, 5 high-speed
// [R5] unused global pins stay ordinary inputs/outputs
// [R6] tristate all user pins during configuration
// [R7] global reset to all flops during configuration
// [R8] tile flops wake in reset state
// [R9] reference from pin, strobe or routing; feedback two ways
// [R10] external feedback only when external path chosen
// [R11] feedback divider multiplies reference frequency
// [R12] output divider 1 to 64, powers of two
// [R13] lock rises when aligned, drops on loss
// [R14] phase shift static or dynamic; relock after settle
// [R15] bypass 0 synthesised clock, 1 reference clock
// [R16] fine delay used only in dynamic mode
// [R17] freeze with both enables holds output, low power
// [R18] global and fabric outputs same frequency
// [R19] pll reset stops clock and clears lock
// [R20] user logic waits for lock before using clock
package gcp_pkg;
	localparam logic [7:0] GCP_OFS_CTRL = 8'h00;
	localparam logic [7:0] GCP_OFS_PLL_CFG = 8'h04;
	localparam logic [7:0] GCP_OFS_DELAY = 8'h08;
	localparam logic [7:0] GCP_OFS_STATUS = 8'h0C;
	localparam logic [7:0] GCP_OFS_TILE0 = 8'h10;
	localparam int GCP_CTRL_G4_PLL = 0;
	localparam int GCP_CTRL_G5_PLL = 1;
	localparam int GCP_CTRL_PIN_CLK = 2;
	localparam int GCP_CFG_REF_SEL = 0;
	localparam int GCP_CFG_FB_EXT = 2;
	localparam int GCP_CFG_BYPASS = 3;
	localparam int GCP_CFG_ODIV = 4;
	localparam int GCP_CFG_FB_DIV = 8;
	localparam int GCP_CFG_DLY_DYN = 15;
	localparam int GCP_CFG_FRZ_A = 16;
	localparam int GCP_CFG_FRZ_B = 17;
	localparam int GCP_TILE_CLK = 0;
	localparam int GCP_TILE_LUT = 3;
	localparam int GCP_TILE_SR_EN = 15;
	localparam int GCP_TILE_SR_PAIR = 16;
	localparam int GCP_TILE_CE_EN = 18;
	localparam int GCP_TILE_CE_PAIR = 19;
	localparam logic [31:0] GCP_RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] GCP_RST_PLL_CFG = 32'h0000_0100;
	localparam logic [31:0] GCP_RST_DELAY = 32'h0000_0000;
	localparam logic [31:0] GCP_RST_TILE = 32'h0000_0000;
	localparam logic [1:0] GCP_REF_PIN = 2'h0;
	localparam logic [1:0] GCP_REF_STROBE = 2'h1;
	localparam logic [1:0] GCP_REF_FABRIC = 2'h2;
	localparam int GCP_ODIV_MAX_LOG = 6;
	localparam int GCP_CLK_MHZ = 50;
	localparam int GCP_LOCK_SETTLE_US = 50;
	localparam int GCP_LOCK_SETTLE_CYC = GCP_LOCK_SETTLE_US * GCP_CLK_MHZ;
	localparam int GCP_LOCK_REF_PERIODS = 4;

	typedef struct packed {
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} gcp_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} gcp_apb_rsp_t;

	typedef enum logic [1:0] {
		GCP_PLL_RESET = 2'h0,
		GCP_PLL_ACQUIRE = 2'h1,
		GCP_PLL_SETTLE = 2'h3,
		GCP_PLL_LOCKED = 2'h2
	} gcp_pll_state_t;
endpackage

/* hdl/gcp_tile_route.sv */
/*
 per-tile routing of the eight global buffers onto clock, lut, set/reset and enable inputs.
 assumes the configuration word is stable and the global buffers are pclk-synchronous.
*/
`timescale 1ns/1ps
module gcp_tile_route
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wake_reset,
	input wire logic [7:0] gbuf,
	input wire logic [31:0] cfg,
	output logic tile_clk,
	output logic [3:0] tile_lut,
	output logic tile_sr,
	output logic tile_ce
);
	typedef struct packed {
		logic clk;
		logic [3:0] lut;
		logic sr;
		logic ce;
	} gcp_tile_state_t;

	gcp_tile_state_t st_reg;
	gcp_tile_state_t st_next;
	logic [2:0] lut_sel;
	logic [1:0] sr_pair;
	logic [1:0] ce_pair;

	always_comb
	begin
		st_next = st_reg;
		sr_pair = cfg[gcp_pkg::GCP_TILE_SR_PAIR +: 2];
		ce_pair = cfg[gcp_pkg::GCP_TILE_CE_PAIR +: 2];
		lut_sel = 3'h0;
		st_next.clk = gbuf[cfg[gcp_pkg::GCP_TILE_CLK +: 3]]; // R1
		for (int i = 0; i < 4; i++)
		begin
			lut_sel = cfg[gcp_pkg::GCP_TILE_LUT + 3 * i +: 3];
			st_next.lut[i] = gbuf[lut_sel]; // R2
		end
		// wake-up forces set/reset so every tile flop starts cleared
		st_next.sr = wake_reset | (cfg[gcp_pkg::GCP_TILE_SR_EN] & gbuf[{sr_pair, 1'b0}]); // R3 R7 R8
		st_next.ce = ~wake_reset & cfg[gcp_pkg::GCP_TILE_CE_EN] & gbuf[{ce_pair, 1'b1}]; // R3
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_reg <= '{clk: 1'b0, lut: 4'h0, sr: 1'b1, ce: 1'b0};
		else
			st_reg <= st_next;
	end

	assign tile_clk = st_reg.clk;
	assign tile_lut = st_reg.lut;
	assign tile_sr = st_reg.sr;
	assign tile_ce = st_reg.ce;
endmodule

/* hdl/gcp_top.sv */
/*
 global clock/control distribution and a digital pll model with apb registers.
 assumes all pins and strobe sources are synchronous to pclk; the pll is synthesised by an
 accumulator, so output edges are quantised to pclk.
*/
`timescale 1ns/1ps
module gcp_top
#(
	parameter int NUM_TILES = 4,
	parameter int LOCK_SETTLE_CYC = gcp_pkg::GCP_LOCK_SETTLE_CYC
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire gcp_pkg::gcp_apb_req_t apb_req,
	output gcp_pkg::gcp_apb_rsp_t apb_rsp,
	input wire logic config_active,
	input wire logic [5:0] global_pin_in,
	input wire logic [5:0] user_pin_out,
	input wire logic [5:0] user_pin_oe,
	output logic [5:0] global_pin_out,
	output logic [5:0] global_pin_oe,
	output logic [5:0] pin_to_fabric,
	output logic global_tristate_control,
	output logic global_wake_reset,
	input wire logic low_power_strobe_source,
	input wire logic high_speed_strobe_source,
	output logic [7:0] global_clock_buffers,
	output logic [NUM_TILES-1:0] tile_clk,
	output logic [NUM_TILES-1:0][3:0] tile_lut,
	output logic [NUM_TILES-1:0] tile_sr,
	output logic [NUM_TILES-1:0] tile_ce,
	input wire logic pll_reference_clock,
	input wire logic fabric_reference,
	input wire logic external_feedback_in,
	input wire logic pll_reset_n,
	input wire logic [7:0] fine_delay_adjust,
	input wire logic pll_freeze_request,
	output logic pll_out_to_global_net,
	output logic pll_out_to_fabric,
	output logic pll_lock
);
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] pll_cfg;
		logic [31:0] delay;
		logic [NUM_TILES-1:0][31:0] tile_cfg;
		logic [7:0] gbuf;
		logic tristate;
		logic wake;
		logic [5:0] pin_out;
		logic [5:0] pin_oe;
		logic [5:0] pin_in;
		gcp_pkg::gcp_pll_state_t pst;
		logic ref_prev;
		logic fb_prev;
		logic fb_seen;
		logic [15:0] per_cnt;
		logic [15:0] ref_period;
		logic [16:0] acc;
		logic vco;
		logic [5:0] div_cnt;
		logic [7:0] last_delay;
		logic [2:0] stable_cnt;
		logic [15:0] settle_cnt;
		logic pll_out;
		logic lock;
	} gcp_state_t;

	gcp_state_t st_reg;
	gcp_state_t st_next;

	// constant reset image: the asynchronous reset branch loads nothing computed
	localparam gcp_state_t ST_RST = '{
		ctrl: gcp_pkg::GCP_RST_CTRL,
		pll_cfg: gcp_pkg::GCP_RST_PLL_CFG,
		delay: gcp_pkg::GCP_RST_DELAY,
		tile_cfg: {NUM_TILES{gcp_pkg::GCP_RST_TILE}},
		tristate: 1'b1,
		wake: 1'b1,
		pst: gcp_pkg::GCP_PLL_RESET,
		default: '0
	};

	////////////////////////////////////////////////////////////////////////////////////////////
	// decoded configuration

	logic [1:0] ref_sel;
	logic fb_ext;
	logic bypass;
	logic [2:0] odiv_log;
	logic [6:0] fb_div;
	logic dly_dyn;
	logic frozen;
	logic [5:0] pin_clk_use;
	logic ref_lvl;
	logic fb_lvl;
	logic ref_rise;
	logic fb_rise;
	logic per_match;
	logic per_timeout;
	logic [7:0] eff_delay;
	logic dly_jump;
	logic disturb;
	logic div_out;
	logic [7:0] addr;
	logic acc_ok;
	logic wr_en;
	logic [31:0] rd_data;
	logic [16:0] acc_sum;
	logic [16:0] diff;

	assign ref_sel = st_reg.pll_cfg[gcp_pkg::GCP_CFG_REF_SEL +: 2];
	assign fb_ext = st_reg.pll_cfg[gcp_pkg::GCP_CFG_FB_EXT];
	assign bypass = st_reg.pll_cfg[gcp_pkg::GCP_CFG_BYPASS];
	assign odiv_log = st_reg.pll_cfg[gcp_pkg::GCP_CFG_ODIV +: 3];
	assign fb_div = st_reg.pll_cfg[gcp_pkg::GCP_CFG_FB_DIV +: 7];
	assign dly_dyn = st_reg.pll_cfg[gcp_pkg::GCP_CFG_DLY_DYN];
	assign pin_clk_use = st_reg.ctrl[gcp_pkg::GCP_CTRL_PIN_CLK +: 6];
	assign frozen = st_reg.pll_cfg[gcp_pkg::GCP_CFG_FRZ_A] & st_reg.pll_cfg[gcp_pkg::GCP_CFG_FRZ_B]
		& pll_freeze_request; // R17

	always_comb
	begin
		case (ref_sel) // R9
			gcp_pkg::GCP_REF_PIN: ref_lvl = pll_reference_clock;
			gcp_pkg::GCP_REF_STROBE: ref_lvl = low_power_strobe_source;
			gcp_pkg::GCP_REF_FABRIC: ref_lvl = fabric_reference;
			default: ref_lvl = pll_reference_clock;
		endcase
	end

	// the internal feedback is the divided output itself
	assign fb_lvl = fb_ext ? external_feedback_in : st_reg.pll_out; // R9 R10
	assign ref_rise = ref_lvl & ~st_reg.ref_prev;
	assign fb_rise = fb_lvl & ~st_reg.fb_prev;
	assign diff = (st_reg.per_cnt > st_reg.ref_period)
		? 17'(st_reg.per_cnt - st_reg.ref_period) : 17'(st_reg.ref_period - st_reg.per_cnt);
	assign per_match = (st_reg.ref_period != 16'h0000) && (diff <= 17'h00001);
	assign per_timeout = (st_reg.per_cnt == 16'hFFFF);
	assign eff_delay = dly_dyn ? fine_delay_adjust : st_reg.delay[7:0]; // R16
	assign dly_jump = (eff_delay != st_reg.last_delay);
	// a phase jump on the output that closes the loop costs lock
	assign disturb = (ref_rise & ~(per_match & st_reg.fb_seen)) | per_timeout
		| (dly_jump & ~fb_ext); // R13 R14
	// step by twice the feedback divider: two toggles per vco period
	assign acc_sum = st_reg.acc + 17'({fb_div, 1'b0}); // R11
	assign div_out = (odiv_log == 3'h0) ? st_reg.vco
		: st_reg.div_cnt[3'(odiv_log - 3'h1)]; // R12

	////////////////////////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait states, unmapped offsets answer with pslverr

	assign addr = apb_req.paddr;

	always_comb
	begin
		acc_ok = 1'b1;
		rd_data = 32'h0000_0000;
		case (addr)
			gcp_pkg::GCP_OFS_CTRL: rd_data = st_reg.ctrl;
			gcp_pkg::GCP_OFS_PLL_CFG: rd_data = st_reg.pll_cfg;
			gcp_pkg::GCP_OFS_DELAY: rd_data = st_reg.delay;
			gcp_pkg::GCP_OFS_STATUS: rd_data = {st_reg.ref_period, 12'h000, st_reg.pst,
				config_active, st_reg.lock};
			default:
			begin
				acc_ok = 1'b0;
				for (int t = 0; t < NUM_TILES; t++)
				begin
					if (addr == 8'(gcp_pkg::GCP_OFS_TILE0 + 4 * t))
					begin
						acc_ok = 1'b1;
						rd_data = st_reg.tile_cfg[t];
					end
				end
			end
		endcase
	end

	assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite & acc_ok;
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~acc_ok;
	assign apb_rsp.prdata = (apb_req.psel & ~apb_req.pwrite & acc_ok) ? rd_data : 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		st_next = st_reg;
		if (wr_en)
		begin
			case (addr)
				gcp_pkg::GCP_OFS_CTRL: st_next.ctrl = {24'h000000, apb_req.pwdata[7:0]};
				gcp_pkg::GCP_OFS_PLL_CFG: st_next.pll_cfg = {14'h0000, apb_req.pwdata[17:0]};
				gcp_pkg::GCP_OFS_DELAY: st_next.delay = {24'h000000, apb_req.pwdata[7:0]};
				default:
				begin
					for (int t = 0; t < NUM_TILES; t++)
					begin
						if (addr == 8'(gcp_pkg::GCP_OFS_TILE0 + 4 * t))
							st_next.tile_cfg[t] = {11'h000, apb_req.pwdata[20:0]};
					end
				end
			endcase
		end

		st_next.gbuf = {global_pin_in[5:4], // R1 R4
			st_reg.ctrl[gcp_pkg::GCP_CTRL_G5_PLL] ? st_reg.pll_out : high_speed_strobe_source,
			st_reg.ctrl[gcp_pkg::GCP_CTRL_G4_PLL] ? st_reg.pll_out : low_power_strobe_source,
			global_pin_in[3:0]}; // R4 R18
		st_next.tristate = config_active; // R6
		st_next.wake = config_active; // R7
		st_next.pin_in = global_pin_in & ~pin_clk_use; // R5
		st_next.pin_out = user_pin_out;
		st_next.pin_oe = user_pin_oe & ~pin_clk_use & {6{~config_active}}; // R5 R6

		if (!pll_reset_n)
		begin
			// held in reset: no clock, no lock, restart acquisition on release
			st_next.pst = gcp_pkg::GCP_PLL_RESET; // R19
			st_next.acc = 17'h00000;
			st_next.vco = 1'b0;
			st_next.div_cnt = 6'h00;
			st_next.pll_out = 1'b0;
			st_next.lock = 1'b0;
			st_next.stable_cnt = 3'h0;
			st_next.settle_cnt = 16'h0000;
			st_next.per_cnt = 16'h0000;
			st_next.fb_seen = 1'b0;
			st_next.ref_prev = ref_lvl;
			st_next.fb_prev = 1'b0;
			st_next.last_delay = eff_delay;
		end
		else if (!frozen)
		begin
			st_next.ref_prev = ref_lvl;
			st_next.fb_prev = fb_lvl;
			st_next.last_delay = eff_delay;
			if (ref_rise)
			begin
				st_next.ref_period = st_reg.per_cnt;
				st_next.per_cnt = 16'h0001;
				st_next.fb_seen = 1'b0;
			end
			else
			begin
				if (!per_timeout)
					st_next.per_cnt = st_reg.per_cnt + 16'h0001;
				if (fb_rise)
					st_next.fb_seen = 1'b1;
			end

			if (dly_jump)
				st_next.acc = {9'h000, eff_delay}; // R14 R16
			else if (acc_sum >= {1'b0, st_reg.ref_period} && st_reg.ref_period != 16'h0000)
			begin
				st_next.acc = 17'(acc_sum - {1'b0, st_reg.ref_period});
				st_next.vco = ~st_reg.vco;
				if (!st_reg.vco)
					st_next.div_cnt = st_reg.div_cnt + 6'h01;
			end
			else
				st_next.acc = acc_sum;

			st_next.pll_out = bypass ? ref_lvl : div_out; // R15

			case (st_reg.pst)
				gcp_pkg::GCP_PLL_RESET:
				begin
					st_next.pst = gcp_pkg::GCP_PLL_ACQUIRE; // R19
				end
				gcp_pkg::GCP_PLL_ACQUIRE:
				begin
					if (disturb)
						st_next.stable_cnt = 3'h0;
					else if (ref_rise)
					begin
						st_next.stable_cnt = st_reg.stable_cnt + 3'h1;
						if (st_reg.stable_cnt == 3'(gcp_pkg::GCP_LOCK_REF_PERIODS - 1))
						begin
							st_next.pst = gcp_pkg::GCP_PLL_SETTLE;
							st_next.settle_cnt = 16'h0000;
						end
					end
				end
				gcp_pkg::GCP_PLL_SETTLE:
				begin
					if (disturb)
					begin
						st_next.pst = gcp_pkg::GCP_PLL_ACQUIRE;
						st_next.stable_cnt = 3'h0;
					end
					else if (st_reg.settle_cnt == 16'(LOCK_SETTLE_CYC - 1))
					begin
						st_next.pst = gcp_pkg::GCP_PLL_LOCKED; // R13 R14
						st_next.lock = 1'b1;
					end
					else
						st_next.settle_cnt = st_reg.settle_cnt + 16'h0001;
				end
				gcp_pkg::GCP_PLL_LOCKED:
				begin
					if (disturb)
					begin
						st_next.pst = gcp_pkg::GCP_PLL_ACQUIRE; // R13
						st_next.lock = 1'b0;
						st_next.stable_cnt = 3'h0;
					end
				end
				default:
				begin
					st_next.pst = gcp_pkg::GCP_PLL_RESET;
					st_next.lock = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_reg <= ST_RST;
		else
			st_reg <= st_next;
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// outputs and tile routing

	assign global_clock_buffers = st_reg.gbuf;
	assign global_tristate_control = st_reg.tristate;
	assign global_wake_reset = st_reg.wake;
	assign global_pin_out = st_reg.pin_out;
	assign global_pin_oe = st_reg.pin_oe;
	assign pin_to_fabric = st_reg.pin_in;
	assign pll_out_to_global_net = st_reg.pll_out; // R18
	assign pll_out_to_fabric = st_reg.pll_out; // R18
	assign pll_lock = st_reg.lock;

	generate
		for (genvar t = 0; t < NUM_TILES; t++)
		begin : g_tile
			gcp_tile_route u_route
			(
				.pclk(pclk),
				.presetn(presetn),
				.wake_reset(st_reg.wake),
				.gbuf(st_reg.gbuf),
				.cfg(st_reg.tile_cfg[t]),
				.tile_clk(tile_clk[t]),
				.tile_lut(tile_lut[t]),
				.tile_sr(tile_sr[t]),
				.tile_ce(tile_ce[t])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_enter_settle;
		st_reg.pst == gcp_pkg::GCP_PLL_SETTLE && $past(st_reg.pst) == gcp_pkg::GCP_PLL_ACQUIRE;
	endsequence

	sequence s_lock_rise;
		$rose(pll_lock);
	endsequence

	chk_tristate_cfg: assert property (config_active |=> global_tristate_control && global_wake_reset
		&& global_pin_oe == 6'h00) else $error("pins not tristated during configuration"); // R6 R7
	chk_pin_gpio: assert property (##1 (pin_to_fabric & $past(pin_clk_use)) == 6'h00)
		else $error("clock-used pin leaks to fabric"); // R5
	chk_gbuf_pins: assert property (##1 {global_clock_buffers[7:6], global_clock_buffers[3:0]}
		== $past(global_pin_in)) else $error("global buffer not following its pin"); // R4
	chk_lock_reset: assert property (!pll_reset_n |=> !pll_lock && !pll_out_to_global_net)
		else $error("pll active while in reset"); // R19
	chk_lock_settle: assert property (s_lock_rise |-> $past(st_reg.pst) == gcp_pkg::GCP_PLL_SETTLE
		&& $past(st_reg.settle_cnt) == 16'(LOCK_SETTLE_CYC - 1))
		else $error("lock rose before settle time"); // R13 R14
	chk_settle_quiet: assert property (s_enter_settle |-> !pll_lock)
		else $error("lock high while settling"); // R13
	chk_bypass_path: assert property (pll_reset_n && bypass && !frozen |=> pll_out_to_fabric
		== $past(ref_lvl)) else $error("bypass does not route reference"); // R15
	chk_freeze_hold: assert property (pll_reset_n && frozen |=> $stable(pll_out_to_global_net))
		else $error("frozen pll output moved"); // R17
	chk_same_freq: assert property (pll_out_to_global_net == pll_out_to_fabric)
		else $error("pll outputs differ"); // R18
	chk_fb_source: assert property (pll_reset_n && !frozen && !fb_ext |=> st_reg.fb_prev
		== $past(st_reg.pll_out)) else $error("external feedback used while internal"); // R10
	chk_tile_wake: assert property (global_wake_reset |=> tile_sr == {NUM_TILES{1'b1}})
		else $error("tile flops not reset at wake-up"); // R8
endmodule

/* sim/gcp_fabric_model.sv */
/*
 fabric-side partner of gcp_top: reference clock oscillator, feedback loop-back and the
 user reset that waits for pll lock.
 assumes pclk is the common system clock and the pll output is pclk-quantised.
*/
`timescale 1ns/1ps
module gcp_fabric_model
#(
	parameter int REF_HALF = 16
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic fb_break,
	input wire logic pll_out_to_fabric,
	input wire logic pll_lock,
	output logic ref_clk,
	output logic fb_ext,
	output logic user_rst_n
);
	typedef struct packed {
		logic [7:0] cnt;
		logic ref_lvl;
		logic [1:0] lock_sync;
	} gcp_fab_state_t;

	gcp_fab_state_t state_reg;
	gcp_fab_state_t state_next;

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		state_next = state_reg;
		state_next.cnt = state_reg.cnt + 8'h01;
		if (state_reg.cnt == 8'(REF_HALF - 1))
		begin
			state_next.cnt = 8'h00;
			state_next.ref_lvl = ~state_reg.ref_lvl;
		end
		// dependent logic stays in reset until lock, and again whenever lock drops
		state_next.lock_sync = {state_reg.lock_sync[0], pll_lock};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign ref_clk = state_reg.ref_lvl;
	// a broken loop is stuck low, only when the bench asks for it
	assign fb_ext = fb_break ? 1'b0 : pll_out_to_fabric;
	assign user_rst_n = state_reg.lock_sync[1];
endmodule

/* sim/global_clock_and_pll_control_tb.sv */
/*
 self-checking bench for gcp_top: register table, configuration-time pin and flop control,
 global buffers, tile routing and the pll.
 assumes gcp_fabric_model supplies the reference and loops the fabric output back.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module global_clock_and_pll_control_tb;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] w;
		logic [31:0] r;
		logic e;
	} gcp_row_t;

	logic pclk = 1'b0;
	logic presetn;
	gcp_pkg::gcp_apb_req_t apb_req;
	gcp_pkg::gcp_apb_rsp_t apb_rsp;
	logic config_active, lp_strobe, hs_strobe, pll_reset_n, pll_freeze_request, fb_break;
	logic [5:0] global_pin_in, user_pin_out, user_pin_oe, global_pin_out, global_pin_oe;
	logic [5:0] pin_to_fabric;
	logic global_tristate_control, global_wake_reset, pll_out_to_global_net;
	logic pll_out_to_fabric, pll_lock, ref_clk, fb_ext, user_rst_n;
	logic pll_reference_clock, fabric_reference, low_power_strobe_source;
	logic [7:0] global_clock_buffers, fine_delay_adjust, gexp;
	logic [3:0] tile_clk, tile_sr, tile_ce;
	logic [3:0][3:0] tile_lut;
	logic [1:0] ref_src;
	logic [31:0] rd;
	logic er;
	int err_count = 0;
	int tests_run = 0;
	int re, oe, hi, df, ll;
	gcp_row_t rows [6];

	always #10 pclk = ~pclk;

	// the reference is steered onto exactly one candidate source at a time
	assign pll_reference_clock = (ref_src == 2'h0) ? ref_clk : 1'b0;
	assign low_power_strobe_source = (ref_src == 2'h1) ? ref_clk : lp_strobe;
	assign fabric_reference = (ref_src == 2'h2) ? ref_clk : 1'b0;

	gcp_top #(.NUM_TILES(4), .LOCK_SETTLE_CYC(20)) u_dut (
		.pclk(pclk),
		.presetn(presetn),
		.apb_req(apb_req),
		.apb_rsp(apb_rsp),
		.config_active(config_active),
		.global_pin_in(global_pin_in),
		.user_pin_out(user_pin_out),
		.user_pin_oe(user_pin_oe),
		.global_pin_out(global_pin_out),
		.global_pin_oe(global_pin_oe),
		.pin_to_fabric(pin_to_fabric),
		.global_tristate_control(global_tristate_control),
		.global_wake_reset(global_wake_reset),
		.low_power_strobe_source(low_power_strobe_source),
		.high_speed_strobe_source(hs_strobe),
		.global_clock_buffers(global_clock_buffers),
		.tile_clk(tile_clk),
		.tile_lut(tile_lut),
		.tile_sr(tile_sr),
		.tile_ce(tile_ce),
		.pll_reference_clock(pll_reference_clock),
		.fabric_reference(fabric_reference),
		.external_feedback_in(fb_ext),
		.pll_reset_n(pll_reset_n),
		.fine_delay_adjust(fine_delay_adjust),
		.pll_freeze_request(pll_freeze_request),
		.pll_out_to_global_net(pll_out_to_global_net),
		.pll_out_to_fabric(pll_out_to_fabric),
		.pll_lock(pll_lock)
	);

	gcp_fabric_model #(.REF_HALF(16)) u_fabric (
		.pclk(pclk),
		.presetn(presetn),
		.fb_break(fb_break),
		.pll_out_to_fabric(pll_out_to_fabric),
		.pll_lock(pll_lock),
		.ref_clk(ref_clk),
		.fb_ext(fb_ext),
		.user_rst_n(user_rst_n)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rdat, output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		apb_req.paddr <= a;
		apb_req.pwrite <= wr;
		apb_req.pwdata <= d;
		apb_req.psel <= 1'b1;
		apb_req.penable <= 1'b0;
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (apb_rsp.pready !== 1'b1 && n < 50);
		rdat = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task automatic wait_lock(input logic lvl, input int lim);
		int n;
		n = 0;
		while (pll_lock !== lvl && n < lim)
		begin
			cyc(1);
			n++;
		end
	endtask

	// counts reference and output rising edges, output high cycles, net mismatches, unlocked cycles
	task automatic win(input int n);
		logic pr, po;
		{re, oe, hi, df, ll} = '0;
		pr = ref_clk;
		po = pll_out_to_fabric;
		repeat (n)
		begin
			cyc(1);
			re += int'(ref_clk && !pr);
			oe += int'(pll_out_to_fabric && !po);
			hi += int'(pll_out_to_fabric === 1'b1);
			df += int'(pll_out_to_fabric !== pll_out_to_global_net);
			ll += int'(pll_lock !== 1'b1);
			pr = ref_clk;
			po = pll_out_to_fabric;
		end
	endtask

	task print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#(20 * 20000);
		err_count++;
		$display("ERROR t=%0t got=%0h exp=%0h", $time, 0, 1);
		print_verdict();
	end

	initial
	begin
		presetn = 1'b0;
		apb_req = '0;
		{config_active, lp_strobe, hs_strobe, pll_reset_n, pll_freeze_request, fb_break} = '0;
		global_pin_in = 6'h00;
		user_pin_out = 6'h15;
		user_pin_oe = 6'h3F;
		fine_delay_adjust = 8'h00;
		ref_src = 2'h0;
		rows = '{'{8'h00, 32'h0000_00FD, 32'h0000_00FD, 1'b0},
			'{8'h04, 32'h0003_8F25, 32'h0003_8F25, 1'b0},
			'{8'h08, 32'h0000_00A5, 32'h0000_00A5, 1'b0},
			'{8'h08, 32'hFFFF_FF3C, 32'h0000_003C, 1'b0},
			'{8'h1C, 32'h001F_FFFF, 32'h001F_FFFF, 1'b0},
			'{8'h20, 32'hDEAD_BEEF, 32'h0000_0000, 1'b1}};
		cyc(3);
		`CHK(global_tristate_control, 1'b1)
		`CHK(global_wake_reset, 1'b1)
		`CHK(tile_sr, 4'hF)
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, gcp_pkg::GCP_OFS_PLL_CFG, 32'h0, rd, er);
		`CHK(rd, gcp_pkg::GCP_RST_PLL_CFG)
		apb(1'b0, gcp_pkg::GCP_OFS_TILE0, 32'h0, rd, er);
		`CHK(rd, gcp_pkg::GCP_RST_TILE)
		@(posedge pclk);
		config_active <= 1'b1;
		cyc(3);
		`CHK({global_tristate_control, global_pin_oe}, 7'h40)
		`CHK({global_wake_reset, tile_sr, tile_ce}, 9'h1F0)
		@(posedge pclk);
		config_active <= 1'b0;
		cyc(3);
		`CHK({global_tristate_control, global_wake_reset}, 2'h0)
		`CHK({global_pin_oe, global_pin_out}, 12'hFD5)
		foreach (rows[i])
		begin
			apb(1'b1, rows[i].a, rows[i].w, rd, er);
			`CHK(er, rows[i].e)
			apb(1'b0, rows[i].a, 32'h0, rd, er);
			`CHK(rd, rows[i].r)
		end
		// pin 0 becomes a clock; tile 1 takes clock 5, luts 7/6/4/1, sr from 6, ce from 1
		apb(1'b1, gcp_pkg::GCP_OFS_CTRL, 32'h0000_0004, rd, er);
		apb(1'b1, 8'h14, 32'h0007_FD0D, rd, er);
		for (int k = 0; k < 2; k++)
		begin
			@(posedge pclk);
			global_pin_in <= k ? 6'h15 : 6'h2A;
			lp_strobe <= (k == 0);
			hs_strobe <= (k == 1);
			gexp = k ? 8'h65 : 8'h9A;
			cyc(3);
			`CHK(global_clock_buffers, gexp)
			`CHK(pin_to_fabric, (k ? 6'h15 : 6'h2A) & 6'h3E)
			`CHK(tile_clk[1], gexp[5])
			`CHK(tile_lut[1], {gexp[7], gexp[6], gexp[4], gexp[1]})
			`CHK({tile_sr[1], tile_ce[1]}, {gexp[6], gexp[1]})
		end
		`CHK(global_pin_oe, 6'h3E)
		apb(1'b1, gcp_pkg::GCP_OFS_PLL_CFG, 32'h0000_0400, rd, er);
		@(posedge pclk);
		pll_reset_n <= 1'b1;
		wait_lock(1'b1, 1000);
		`CHK(pll_lock, 1'b1)
		for (int k = 0; k < 3; k++)
		begin
			apb(1'b1, gcp_pkg::GCP_OFS_PLL_CFG, 32'h0000_0400 | (k << 4), rd, er);
			cyc(200);
			win(256);
			`CHK((oe >= (32 >> k) - 1 && oe <= (32 >> k) + 1), 1'b1)
			`CHK(df, 0)
		end
		apb(1'b1, gcp_pkg::GCP_OFS_PLL_CFG, 32'h0000_0400, rd, er);
		wait_lock(1'b1, 1000);
		@(posedge pclk);
		fine_delay_adjust <= 8'h40;
		win(64);
		`CHK(ll, 0)
		apb(1'b1, gcp_pkg::GCP_OFS_PLL_CFG, 32'h0000_8400, rd, er);
		cyc(5);
		wait_lock(1'b1, 1000);
		@(posedge pclk);
		fine_delay_adjust <= 8'h41;
		wait_lock(1'b0, 10);
		`CHK(pll_lock, 1'b0)
		wait_lock(1'b1, 1000);
		`CHK(pll_lock, 1'b1)
		apb(1'b1, gcp_pkg::GCP_OFS_PLL_CFG, 32'h0000_0404, rd, er);
		cyc(5);
		wait_lock(1'b1, 1000);
		`CHK(pll_lock, 1'b1)
		@(posedge pclk);
		fb_break <= 1'b1;
		wait_lock(1'b0, 200);
		`CHK(pll_lock, 1'b0)
		apb(1'b1, gcp_pkg::GCP_OFS_PLL_CFG, 32'h0000_0400, rd, er);
		cyc(5);
		wait_lock(1'b1, 1000);
		`CHK(pll_lock, 1'b1)
		fb_break <= 1'b0;
		apb(1'b1, gcp_pkg::GCP_OFS_PLL_CFG, 32'h0003_0400, rd, er);
		pll_freeze_request <= 1'b1;
		cyc(3);
		win(64);
		`CHK(oe, 0)
		apb(1'b1, gcp_pkg::GCP_OFS_PLL_CFG, 32'h0001_0400, rd, er);
		cyc(5);
		win(64);
		`CHK((oe > 0), 1'b1)
		pll_freeze_request <= 1'b0;
		for (int k = 0; k < 3; k++)
		begin
			@(posedge pclk);
			ref_src <= 2'(k);
			apb(1'b1, gcp_pkg::GCP_OFS_PLL_CFG, 32'h0000_0408 | k, rd, er);
			cyc(4);
			win(128);
			`CHK((oe >= re - 1 && oe <= re + 1 && re > 2), 1'b1)
			@(posedge pclk);
			ref_src <= 2'((k + 1) % 3);
			cyc(4);
			win(128);
			`CHK(oe, 0)
		end
		ref_src <= 2'h0;
		apb(1'b1, gcp_pkg::GCP_OFS_PLL_CFG, 32'h0000_0400, rd, er);
		pll_reset_n <= 1'b0;
		cyc(2);
		`CHK(pll_lock, 1'b0)
		win(40);
		`CHK(hi, 0)
		`CHK(user_rst_n, 1'b0)
		@(posedge pclk);
		pll_reset_n <= 1'b1;
		wait_lock(1'b1, 1000);
		`CHK(pll_lock, 1'b1)
		cyc(3);
		`CHK(user_rst_n, 1'b1)
		apb(1'b0, gcp_pkg::GCP_OFS_STATUS, 32'h0, rd, er);
		`CHK(rd, 32'h0020_0009)
		print_verdict();
	end
endmodule
